// *** design/acr_control.sv ***
module acr_control (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic bus_system_reset,
   input wire logic common_front_in,
   input wire logic common_start_stop_in,
   input wire logic conversion_inhibit_in,
   input wire logic fast_abort_in,
   input wire logic reset_pulse_in,
   input wire logic chain_busy_in,
   input wire logic data_present_line_in,
   input wire logic stop_scope_jumper,
   input wire logic conversion_done,
   input wire logic analog_reset_active,
   input wire logic memory_test_mode,
   input wire logic buffer_store,
   input wire logic buffer_release,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic busy_out,
   output logic data_present_line_out,
   output logic data_present_line_oe_n,
   output logic conversion_start,
   output logic conversion_abort,
   output logic time_section_clear,
   output logic data_reset,
   output logic soft_reset,
   output logic [23:0] end_of_block_count,
   output logic [4:0] write_ptr,
   output logic [4:0] read_ptr,
   output logic buffer_full,
   output logic buffer_empty
);
   // ----------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------
   logic [acr_pkg::SYNC_W-1:0] sync_a;
   logic [acr_pkg::SYNC_W-1:0] sync_b;
   logic [acr_pkg::SYNC_W-1:0] raw_in;
   logic common_q;
   logic abort_q;
   assign raw_in = {bus_system_reset, stop_scope_jumper, data_present_line_in, chain_busy_in,
                    reset_pulse_in, fast_abort_in, conversion_inhibit_in,
                    common_start_stop_in, common_front_in};

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
      end
   end

   logic common_lvl;
   logic inhibit_s;
   logic abort_s;
   logic reset_pulse_s;
   logic chain_busy_s;
   logic chain_data_s;
   logic chain_scope_s;
   logic hw_reset_s;
   assign common_lvl = sync_b[0] | sync_b[1];
   assign inhibit_s = sync_b[2];
   assign abort_s = sync_b[3];
   assign reset_pulse_s = sync_b[4];
   assign chain_busy_s = sync_b[5];
   assign chain_data_s = sync_b[6];
   assign chain_scope_s = sync_b[7];
   assign hw_reset_s = sync_b[8];

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         common_q <= 1'b0;
         abort_q <= 1'b0;
      end else begin
         common_q <= common_lvl;
         abort_q <= abort_s;
      end
   end

   logic common_rise;
   logic abort_rise;
   assign common_rise = common_lvl & ~common_q;
   assign abort_rise = abort_s & ~abort_q;

   // ----------------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------------
   logic [15:0] bit_set1;
   logic [15:0] bit_set2;
   logic [15:0] control1;
   logic [7:0] fast_window;
   logic wr_set1;
   logic wr_clr1;
   logic wr_set2;
   logic wr_clr2;
   logic wr_ctrl1;
   logic wr_window;
   logic wr_single;
   assign wr_set1 = reg_wr && (reg_addr == acr_pkg::REG_BIT_SET1);
   assign wr_clr1 = reg_wr && (reg_addr == acr_pkg::REG_BIT_CLR1);
   assign wr_set2 = reg_wr && (reg_addr == acr_pkg::REG_BIT_SET2);
   assign wr_clr2 = reg_wr && (reg_addr == acr_pkg::REG_BIT_CLR2);
   assign wr_ctrl1 = reg_wr && (reg_addr == acr_pkg::REG_CONTROL1);
   assign wr_window = reg_wr && (reg_addr == acr_pkg::REG_FAST_WINDOW);
   assign wr_single = reg_wr && (reg_addr == acr_pkg::REG_SINGLE_RESET);

   // reset sources; soft reset is held off its own register so it cannot end itself
   logic pulse_soft;
   logic pulse_data;
   assign pulse_soft = reset_pulse_s & control1[acr_pkg::RESET_SCOPE_BIT];
   assign pulse_data = reset_pulse_s & ~control1[acr_pkg::RESET_SCOPE_BIT];
   assign soft_reset = bit_set1[acr_pkg::SOFT_RESET_BIT] | pulse_soft | wr_single | hw_reset_s;
   assign data_reset = soft_reset | bit_set2[acr_pkg::CLEAR_DATA_BIT] | pulse_data;

   // first bit-set register: hardware reset only
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_set1 <= acr_pkg::BIT_SET1_RESET;
      end else if (hw_reset_s) begin
         bit_set1 <= acr_pkg::BIT_SET1_RESET;
      end else if (wr_set1) begin
         bit_set1 <= bit_set1 | reg_wdata;
      end else if (wr_clr1) begin
         bit_set1 <= bit_set1 & ~reg_wdata;
      end
   end

   // second bit-set register: reset to BIT_SET2_RESET by software reset too
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bit_set2 <= acr_pkg::BIT_SET2_RESET;
      end else if (soft_reset) begin
         bit_set2 <= acr_pkg::BIT_SET2_RESET;
      end else if (wr_set2) begin
         bit_set2 <= bit_set2 | reg_wdata;
      end else if (wr_clr2) begin
         bit_set2 <= bit_set2 & ~reg_wdata;
      end
   end

   // control and window: kept across software reset so a pulse reset stays scoped
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         control1 <= acr_pkg::CONTROL1_RESET;
         fast_window <= acr_pkg::FAST_WINDOW_RESET;
      end else if (hw_reset_s) begin
         control1 <= acr_pkg::CONTROL1_RESET;
         fast_window <= acr_pkg::FAST_WINDOW_RESET;
      end else begin
         if (wr_ctrl1) begin
            control1 <= reg_wdata;
         end
         if (wr_window) begin
            fast_window <= reg_wdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // event buffer pointers
   // ----------------------------------------------------------------------
   logic last_was_write;
   logic do_write;
   logic do_read;
   assign do_write = buffer_store & ~buffer_full;
   assign do_read = buffer_release & ~buffer_empty;
   assign buffer_full = (write_ptr == read_ptr) & last_was_write;
   assign buffer_empty = (write_ptr == read_ptr) & ~last_was_write;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         write_ptr <= '0;
         read_ptr <= '0;
         last_was_write <= 1'b0;
      end else if (data_reset) begin
         write_ptr <= '0;
         read_ptr <= '0;
         last_was_write <= 1'b0;
      end else begin
         if (do_write) begin
            write_ptr <= write_ptr + 5'h01;
         end
         if (do_read) begin
            read_ptr <= read_ptr + 5'h01;
         end
         if (do_write != do_read) begin
            last_was_write <= do_write;
         end
      end
   end

   // ----------------------------------------------------------------------
   // busy and acceptance
   // ----------------------------------------------------------------------
   acr_pkg::acr_state_e state;
   logic busy;
   logic stop_now;
   logic accepted;
   // analog reset covers our own data reset too, so busy spans all of it
   assign busy = (state != acr_pkg::ACR_IDLE) | analog_reset_active | data_reset
                 | buffer_full | memory_test_mode;
   assign stop_now = busy | (chain_scope_s & chain_busy_s);
   assign accepted = common_rise & ~inhibit_s & ~abort_s & ~stop_now;

   // ----------------------------------------------------------------------
   // conversion sequencer with fast clear window
   // ----------------------------------------------------------------------
   logic [7:0] window_cnt;
   logic [3:0] holdoff_cnt;
   logic in_window;
   assign in_window = (window_cnt != acr_pkg::WINDOW_ZERO);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state <= acr_pkg::ACR_IDLE;
         window_cnt <= acr_pkg::WINDOW_ZERO;
         holdoff_cnt <= acr_pkg::HOLDOFF_ZERO;
      end else if (data_reset) begin
         state <= acr_pkg::ACR_IDLE;
         window_cnt <= acr_pkg::WINDOW_ZERO;
         holdoff_cnt <= acr_pkg::HOLDOFF_ZERO;
      end else begin
         case (state)
            acr_pkg::ACR_IDLE: begin
               if (accepted) begin
                  state <= acr_pkg::ACR_CONVERT;
                  window_cnt <= fast_window;
               end
            end
            acr_pkg::ACR_CONVERT: begin
               if (abort_rise && in_window) begin
                  state <= acr_pkg::ACR_HOLDOFF;
                  holdoff_cnt <= acr_pkg::HOLDOFF_LOAD;
               end else if (conversion_done) begin
                  state <= acr_pkg::ACR_IDLE;
               end
               if (in_window) begin
                  window_cnt <= window_cnt - 8'h01;
               end
            end
            acr_pkg::ACR_HOLDOFF: begin
               // early pulses from the trigger source are refused here
               if (holdoff_cnt == acr_pkg::HOLDOFF_ZERO) begin
                  state <= acr_pkg::ACR_IDLE;
               end else begin
                  holdoff_cnt <= holdoff_cnt - 4'h1;
               end
            end
            default: begin
               state <= acr_pkg::ACR_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         conversion_start <= 1'b0;
         conversion_abort <= 1'b0;
         time_section_clear <= 1'b0;
      end else begin
         conversion_start <= (state == acr_pkg::ACR_IDLE) & accepted & ~data_reset;
         conversion_abort <= (state == acr_pkg::ACR_CONVERT) & abort_rise & in_window
                             & ~data_reset;
         time_section_clear <= data_reset | ((state == acr_pkg::ACR_CONVERT) & abort_rise
                               & in_window);
      end
   end

   // ----------------------------------------------------------------------
   // event counter
   // ----------------------------------------------------------------------
   logic [acr_pkg::COUNT_W-1:0] event_count;
   logic count_hit;
   assign count_hit = bit_set2[acr_pkg::COUNT_ALL_BIT] ? common_rise : accepted;
   assign end_of_block_count = event_count;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         event_count <= '0;
      end else if (data_reset) begin
         event_count <= '0;
      end else if (count_hit) begin
         event_count <= event_count + 24'h000001;
      end
   end

   // ----------------------------------------------------------------------
   // pins and read back
   // ----------------------------------------------------------------------
   logic [15:0] status1;
   always_comb begin
      status1 = acr_pkg::READ_ZERO;
      status1[acr_pkg::ST_DATA_PRESENT] = ~buffer_empty;
      status1[acr_pkg::ST_CHAIN_DATA] = chain_data_s;
      status1[acr_pkg::ST_BUSY] = busy;
      status1[acr_pkg::ST_GLOBAL_BUSY] = busy | chain_busy_s;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         busy_out <= 1'b0;
         data_present_line_out <= 1'b0;
         data_present_line_oe_n <= 1'b1;
      end else begin
         busy_out <= busy;
         data_present_line_out <= ~buffer_empty;
         data_present_line_oe_n <= buffer_empty; // wired-or: drive only while asserting
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= acr_pkg::READ_ZERO;
      end else if (!reg_rd) begin
         reg_rdata <= acr_pkg::READ_ZERO;
      end else if (reg_addr == acr_pkg::REG_BIT_SET1) begin
         reg_rdata <= bit_set1;
      end else if (reg_addr == acr_pkg::REG_BIT_SET2) begin
         reg_rdata <= bit_set2;
      end else if (reg_addr == acr_pkg::REG_CONTROL1) begin
         reg_rdata <= control1;
      end else if (reg_addr == acr_pkg::REG_STATUS1) begin
         reg_rdata <= status1;
      end else if (reg_addr == acr_pkg::REG_EVENT_COUNT_LOW) begin
         reg_rdata <= event_count[acr_pkg::COUNT_LOW_W-1:0];
      end else if (reg_addr == acr_pkg::REG_EVENT_COUNT_HIGH) begin
         reg_rdata <= {8'h00, event_count[acr_pkg::COUNT_W-1:acr_pkg::COUNT_LOW_W]};
      end else if (reg_addr == acr_pkg::REG_FAST_WINDOW) begin
         reg_rdata <= {8'h00, fast_window};
      end else begin
         reg_rdata <= acr_pkg::READ_ZERO;
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   AST_COUNT_ALL: assert property (@(posedge sys_clk) disable iff (!rstn)
      (common_rise && bit_set2[acr_pkg::COUNT_ALL_BIT] && !data_reset)
      |=> event_count == $past(event_count) + 24'h000001)
      else $error("count-all mode missed a common pulse");
   AST_COUNT_ACCEPTED: assert property (@(posedge sys_clk) disable iff (!rstn)
      (!bit_set2[acr_pkg::COUNT_ALL_BIT] && !accepted && !data_reset)
      |=> event_count == $past(event_count))
      else $error("accepted-only mode counted a refused pulse");
   AST_BUSY_STATUS: assert property (@(posedge sys_clk) disable iff (!rstn)
      1'b1 |=> busy_out == $past(busy))
      else $error("busy output did not follow busy");
   AST_BUSY_ON_START: assert property (@(posedge sys_clk) disable iff (!rstn)
      conversion_start |-> busy && state == acr_pkg::ACR_CONVERT)
      else $error("conversion started without busy");
   AST_NO_START_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(state) != acr_pkg::ACR_IDLE |-> !conversion_start)
      else $error("common pulse accepted while busy");
   AST_DATA_RESET_CLEARS: assert property (@(posedge sys_clk) disable iff (!rstn)
      data_reset |=> event_count == '0 && write_ptr == '0 && read_ptr == '0)
      else $error("data reset left counter or pointers");
   AST_SINGLE_SHOT: assert property (@(posedge sys_clk) disable iff (!rstn)
      wr_single |-> (soft_reset && data_reset) ##1 (bit_set2 == acr_pkg::BIT_SET2_RESET))
      else $error("single-shot write did not reset");
   AST_ABORT_HOLDOFF: assert property (@(posedge sys_clk) disable iff (!rstn)
      conversion_abort && !data_reset |-> time_section_clear
      ##1 (!conversion_start) [*8])
      else $error("abort did not clear or start came too soon");
   AST_INHIBIT: assert property (@(posedge sys_clk) disable iff (!rstn)
      inhibit_s |=> !conversion_start)
      else $error("conversion started under inhibit");
   AST_FULL_FLAG: assert property (@(posedge sys_clk) disable iff (!rstn)
      buffer_full |-> !buffer_empty && busy)
      else $error("full buffer not busy or also empty");
endmodule : acr_control

// *** design/acr_pkg.sv ***
package acr_pkg;
   // ----------------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------------
   localparam logic [3:0] REG_BIT_SET1 = 4'h0;
   localparam logic [3:0] REG_BIT_CLR1 = 4'h1;
   localparam logic [3:0] REG_BIT_SET2 = 4'h2;
   localparam logic [3:0] REG_BIT_CLR2 = 4'h3;
   localparam logic [3:0] REG_CONTROL1 = 4'h4;
   localparam logic [3:0] REG_STATUS1 = 4'h5;
   localparam logic [3:0] REG_SINGLE_RESET = 4'h6;
   localparam logic [3:0] REG_EVENT_COUNT_LOW = 4'h7;
   localparam logic [3:0] REG_EVENT_COUNT_HIGH = 4'h8;
   localparam logic [3:0] REG_FAST_WINDOW = 4'h9;
   // ----------------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------------
   localparam int SOFT_RESET_BIT = 7;
   localparam int CLEAR_DATA_BIT = 2;
   localparam int COUNT_ALL_BIT = 14;
   localparam int RESET_SCOPE_BIT = 4;
   localparam int ST_DATA_PRESENT = 0;
   localparam int ST_CHAIN_DATA = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_GLOBAL_BUSY = 3;
   localparam logic [15:0] BIT_SET1_RESET = 16'h0000;
   localparam logic [15:0] BIT_SET2_RESET = 16'h4000;
   localparam logic [15:0] CONTROL1_RESET = 16'h0000;
   localparam logic [7:0] FAST_WINDOW_RESET = 8'h10;
   localparam logic [15:0] READ_ZERO = 16'h0000;
   // ----------------------------------------------------------------------
   // sizes and timing
   // ----------------------------------------------------------------------
   localparam int COUNT_W = 24;
   localparam int COUNT_LOW_W = 16;
   localparam int PTR_W = 5;
   localparam int SYNC_W = 9;
   localparam int CLK_PERIOD_NS = 50;
   localparam int HOLDOFF_NS = 600;
   localparam int HOLDOFF_CYC = (HOLDOFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] HOLDOFF_LOAD = 4'(HOLDOFF_CYC);
   localparam logic [3:0] HOLDOFF_ZERO = 4'h0;
   localparam logic [7:0] WINDOW_ZERO = 8'h00;
   // ----------------------------------------------------------------------
   // conversion sequencer
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ACR_IDLE = 2'b00,
      ACR_CONVERT = 2'b01,
      ACR_HOLDOFF = 2'b10
   } acr_state_e;
endpackage : acr_pkg

// *** verification/acr_trig_model.sv ***
module acr_trig_model (
   input wire logic sys_clk,
   output logic common_start_stop_in,
   output logic fast_abort_in
);
   timeunit 1ns;
   timeprecision 1ns;
   realtime last_abort = -1.0e6;
   initial begin
      common_start_stop_in = 1'b0;
      fast_abort_in = 1'b0;
   end
   // margin over the minimum spacing, as a real trigger source keeps
   task automatic fire();
      while ($realtime < last_abort + 2 * acr_pkg::HOLDOFF_NS) @(negedge sys_clk);
      common_start_stop_in = 1'b1;
      repeat (3) @(negedge sys_clk);
      common_start_stop_in = 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask : fire
   task automatic abort();
      fast_abort_in = 1'b1;
      last_abort = $realtime;
      repeat (3) @(negedge sys_clk);
      fast_abort_in = 1'b0;
   endtask : abort
endmodule : acr_trig_model

// *** verification/acr_control_count_reset_test.sv ***
module acr_control_count_reset_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0, rstn = 1'b0, bus_system_reset = 1'b0, common_front_in = 1'b0;
   logic conversion_inhibit_in = 1'b0, reset_pulse_in = 1'b0, chain_busy_in = 1'b0;
   logic stop_scope_jumper = 1'b0, conversion_done = 1'b0, analog_reset_active = 1'b0;
   logic memory_test_mode = 1'b0, buffer_store = 1'b0, buffer_release = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, mid;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
   logic com_in, fast_abort_in_in, busy_out, dp_out, dp_oe_n, conv_start, conv_abort, tsc;
   logic data_reset, soft_reset, buffer_full, buffer_empty, dp_line;
   logic [23:0] end_of_block_word;
   int n_mismatch = 0, samples_checked = 0, n_start = 0, n_abort = 0, n_clear = 0;
   // wired-or chain line as read back, this board alone on it
   assign dp_line = !dp_oe_n && dp_out;
   always #25 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (conv_start === 1'b1) n_start++;
      if (conv_abort === 1'b1) n_abort++;
      if (tsc === 1'b1) n_clear++;
   end
   acr_trig_model tm (.sys_clk(sys_clk), .common_start_stop_in(com_in), .fast_abort_in(fast_abort_in_in));
   acr_control dut_u (.sys_clk(sys_clk), .rstn(rstn), .bus_system_reset(bus_system_reset),
      .common_front_in(common_front_in), .common_start_stop_in(com_in),
      .conversion_inhibit_in(conversion_inhibit_in), .fast_abort_in(fast_abort_in_in),
      .reset_pulse_in(reset_pulse_in), .chain_busy_in(chain_busy_in),
      .data_present_line_in(dp_line), .stop_scope_jumper(stop_scope_jumper),
      .conversion_done(conversion_done), .analog_reset_active(analog_reset_active),
      .memory_test_mode(memory_test_mode), .buffer_store(buffer_store),
      .buffer_release(buffer_release), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .busy_out(busy_out),
      .data_present_line_out(dp_out), .data_present_line_oe_n(dp_oe_n),
      .conversion_start(conv_start), .conversion_abort(conv_abort), .time_section_clear(tsc),
      .data_reset(data_reset), .soft_reset(soft_reset), .end_of_block_count(end_of_block_word),
      .write_ptr(), .read_ptr(), .buffer_full(buffer_full), .buffer_empty(buffer_empty));
   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [23:0] e, input logic [23:0] g);
      samples_checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      #1 mid = soft_reset;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      reg_rd = 1'b1;
      reg_addr = a;
      cyc(2);
      v = reg_rdata;
      reg_rd = 1'b0;
      cyc(1);
   endtask : rd
   task automatic done();
      conversion_done = 1'b1;
      cyc(1);
      conversion_done = 1'b0;
      cyc(2);
   endtask : done
   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd(acr_pkg::REG_BIT_SET2, rv);
      chk("set2", 24'h004000, 24'(rv));
      rd(acr_pkg::REG_FAST_WINDOW, rv);
      chk("window", 24'h000010, 24'(rv));
      rd(4'hF, rv);
      chk("unmapped", 24'h0, 24'(rv));
   endtask : t_reset
   task automatic t_count_all();
      tm.fire();
      chk("busy", 24'h1, 24'(busy_out));
      rd(acr_pkg::REG_STATUS1, rv);
      chk("st busy", 24'h00000C, 24'(rv & 16'h000C));
      tm.fire();
      done();
      chk("busy", 24'h0, 24'(busy_out));
      chk("starts", 24'h1, 24'(n_start));
      chk("eob", 24'h2, end_of_block_word);
      rd(acr_pkg::REG_EVENT_COUNT_LOW, rv);
      chk("cnt low", 24'h2, 24'(rv));
      rd(acr_pkg::REG_EVENT_COUNT_HIGH, rv);
      chk("cnt high", 24'h0, 24'(rv));
   endtask : t_count_all
   task automatic t_accepted();
      wr(acr_pkg::REG_BIT_CLR2, 16'h4000);
      conversion_inhibit_in = 1'b1;
      tm.fire();
      chk("eob", 24'h2, end_of_block_word);
      chk("starts", 24'h1, 24'(n_start));
      conversion_inhibit_in = 1'b0;
      cyc(3);
      tm.fire();
      chk("eob", 24'h3, end_of_block_word);
      tm.abort();
      cyc(2);
      chk("aborts", 24'h1, 24'(n_abort));
      chk("clears", 24'h1, 24'(n_clear));
      chk("busy", 24'h1, 24'(busy_out));
      tm.fire();
      chk("starts", 24'h3, 24'(n_start));
      chk("eob", 24'h4, end_of_block_word);
      done();
   endtask : t_accepted
   task automatic t_resets();
      wr(acr_pkg::REG_BIT_SET2, 16'h0004);
      chk("dreset", 24'h1, 24'(data_reset));
      chk("tsc", 24'h1, 24'(tsc));
      rd(acr_pkg::REG_EVENT_COUNT_LOW, rv);
      chk("cnt low", 24'h0, 24'(rv));
      rd(acr_pkg::REG_BIT_SET2, rv);
      chk("set2", 24'h000004, 24'(rv));
      wr(acr_pkg::REG_BIT_CLR2, 16'h0004);
      chk("dreset", 24'h0, 24'(data_reset));
      wr(acr_pkg::REG_BIT_SET1, 16'h0080);
      chk("sreset", 24'h1, 24'(soft_reset));
      rd(acr_pkg::REG_BIT_SET2, rv);
      chk("set2", 24'h004000, 24'(rv));
      wr(acr_pkg::REG_BIT_CLR1, 16'h0080);
      chk("sreset", 24'h0, 24'(soft_reset));
      wr(acr_pkg::REG_SINGLE_RESET, 16'h0000);
      chk("shot mid", 24'h1, 24'(mid));
      chk("shot end", 24'h0, 24'(soft_reset));
      reset_pulse_in = 1'b1;
      cyc(4);
      chk("pulse d", 24'h1, 24'(data_reset));
      chk("pulse s", 24'h0, 24'(soft_reset));
      reset_pulse_in = 1'b0;
      cyc(4);
      wr(acr_pkg::REG_CONTROL1, 16'h0010);
      reset_pulse_in = 1'b1;
      cyc(4);
      chk("pulse s", 24'h1, 24'(soft_reset));
      reset_pulse_in = 1'b0;
      bus_system_reset = 1'b1;
      cyc(4);
      chk("hw s", 24'h1, 24'(soft_reset));
      bus_system_reset = 1'b0;
      cyc(4);
      rd(acr_pkg::REG_CONTROL1, rv);
      chk("ctrl1", 24'h0, 24'(rv));
   endtask : t_resets
   task automatic t_buffer();
      repeat (32) begin
         buffer_store = 1'b1;
         cyc(1);
         buffer_store = 1'b0;
         cyc(1);
      end
      chk("full", 24'h1, 24'(buffer_full));
      chk("busy", 24'h1, 24'(busy_out));
      chk("oe_n", 24'h0, 24'(dp_oe_n));
      cyc(3);
      rd(acr_pkg::REG_STATUS1, rv);
      chk("st dp", 24'h3, 24'(rv & 16'h0003));
      repeat (32) begin
         buffer_release = 1'b1;
         cyc(1);
         buffer_release = 1'b0;
         cyc(1);
      end
      chk("empty", 24'h1, 24'(buffer_empty));
      chk("oe_n", 24'h1, 24'(dp_oe_n));
      analog_reset_active = 1'b1;
      cyc(2);
      chk("busy", 24'h1, 24'(busy_out));
      analog_reset_active = 1'b0;
      memory_test_mode = 1'b1;
      cyc(2);
      chk("busy", 24'h1, 24'(busy_out));
      memory_test_mode = 1'b0;
      cyc(2);
      chk("busy", 24'h0, 24'(busy_out));
   endtask : t_buffer
   task automatic t_chain();
      stop_scope_jumper = 1'b1;
      chain_busy_in = 1'b1;
      cyc(4);
      rd(acr_pkg::REG_STATUS1, rv);
      chk("st gbusy", 24'h8, 24'(rv & 16'h0008));
      tm.fire();
      chk("starts", 24'h3, 24'(n_start));
      stop_scope_jumper = 1'b0;
      cyc(4);
      common_front_in = 1'b1;
      cyc(3);
      common_front_in = 1'b0;
      cyc(3);
      chk("starts", 24'h4, 24'(n_start));
      // window of 16 cycles has run out: this fast clear must be ignored
      cyc(16);
      tm.abort();
      cyc(2);
      chk("late abort", 24'h1, 24'(n_abort));
      chk("busy", 24'h1, 24'(busy_out));
      done();
      chain_busy_in = 1'b0;
   endtask : t_chain
   task automatic give_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      cyc(6);
      rstn = 1'b1;
      cyc(2);
      t_reset();
      t_count_all();
      t_accepted();
      t_resets();
      t_buffer();
      t_chain();
      give_verdict();
   end
endmodule : acr_control_count_reset_test
